// ---- design/pcr_port_regs.sv ----
// configuration and data registers of the seven i/o ports
`timescale 1ns/1ps
module pcr_port_regs
  import pcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // microcontroller register access
  input wire logic bus_cs_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [7:0] bus_rdata_o,
  // pins, one byte per port, A in index 0 up to G in index 6
  input wire logic [6:0][7:0] port_pins_i,
  output logic [6:0][7:0] pin_out_o,
  output logic [6:0][7:0] pin_oe_o,
  output logic [6:0][7:0] fast_slew_o,
  // logic array side
  input wire logic [6:0][7:0] array_oe_i,
  input wire logic [7:0] cell_route_a_i,
  input wire logic [7:0] cell_route_b_i,
  input wire logic [7:0] external_chip_selects_i,
  input wire logic ecs_to_c_i,
  input wire logic ecs_to_f_i,
  input wire logic [15:0] cell_load_i,
  input wire logic [15:0] cell_next_i,
  input wire logic [2:0] in_cell_capture_i,
  input wire logic [2:0][7:0] address_out_i,
  output logic [7:0] a_group_output_cells_o,
  output logic [7:0] b_group_output_cells_o,
  output logic [2:0][7:0] input_logic_cell_o
);

  // software registers, one byte per port
  logic [7:0] pin_dir_select [NUM_PORTS];
  logic [7:0] pin_driver_style [NUM_PORTS];
  logic [7:0] pin_output_latch [NUM_PORTS];
  logic [7:0] port_setup_control [NUM_PORTS];
  logic [15:0] logic_cell_load_block;
  logic [2:0][7:0] in_cells;
  logic [15:0] output_logic_cell;
  logic [6:0][7:0] driver_active;
  logic [6:0][7:0] pin_data;

  // address split: port in the high nibble, register in the low one
  wire logic [3:0] sel_port = bus_addr_i[7:4];
  wire logic [3:0] sel_reg = bus_addr_i[3:0];
  wire logic port_ok = sel_port < 4'(NUM_PORTS);
  wire logic wr_go = bus_cs_i & bus_wr_i & port_ok; // R19
  wire logic rd_go = bus_cs_i & bus_rd_i & port_ok; // R19
  wire logic [7:0] sel_mask = port_mask(sel_port);

  // per-register write strobes; read-only indexes have none
  wire logic we_dir = wr_go & (sel_reg == REG_DIR);
  wire logic we_drv = wr_go & (sel_reg == REG_DRIVER);
  wire logic we_latch = wr_go & (sel_reg == REG_OUT_LATCH);
  wire logic ctrl_port =
    (sel_port == PORT_E) | (sel_port == PORT_F) | (sel_port == PORT_G);
  wire logic we_ctrl = wr_go & (sel_reg == REG_CONTROL) & ctrl_port; // R17
  wire logic cell_port = (sel_port == PORT_A) | (sel_port == PORT_B);
  wire logic we_cell = wr_go & (sel_reg == REG_CELL_ACCESS) & cell_port;
  wire logic we_block = wr_go & (sel_reg == REG_LOAD_BLOCK) & cell_port;

  // bus load strobes for the sixteen cells, A group in the low byte
  wire logic [15:0] cell_we = {{8{we_cell & (sel_port == PORT_B)}},
                               {8{we_cell & (sel_port == PORT_A)}}}; // R10
  wire logic [15:0] cell_wdata = {bus_wdata_i, bus_wdata_i};

  // configuration registers, power up cleared
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        pin_dir_select[p] <= REG_RESET; // R2 R16
        pin_driver_style[p] <= REG_RESET; // R5 R6 R16
        port_setup_control[p] <= REG_RESET; // R16
      end
    end
    else
    begin
      // port D keeps only its low four bits
      if (we_dir)
        pin_dir_select[sel_port[2:0]] <= bus_wdata_i & sel_mask; // R4
      if (we_drv)
        pin_driver_style[sel_port[2:0]] <= bus_wdata_i & sel_mask; // R7
      if (we_ctrl)
        port_setup_control[sel_port[2:0]] <= bus_wdata_i; // R17
    end
  end

  // output latches
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
        pin_output_latch[p] <= REG_RESET;
    end
    else if (we_latch)
      pin_output_latch[sel_port[2:0]] <= bus_wdata_i & sel_mask; // R9
  end

  // load-block mask for the output cells, unblocked after reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      logic_cell_load_block <= 16'h0000; // R11
    else if (we_block && sel_port == PORT_A)
      logic_cell_load_block[7:0] <= bus_wdata_i; // R11
    else if (we_block && sel_port == PORT_B)
      logic_cell_load_block[15:8] <= bus_wdata_i; // R11
  end

  // output logic cells of ports A and B
  pcr_out_cells #(
    .W(16)
  ) u_cells (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .bus_we_i(cell_we),
    .bus_data_i(cell_wdata),
    .block_i(logic_cell_load_block),
    .array_load_i(cell_load_i),
    .array_next_i(cell_next_i),
    .cells_o(output_logic_cell)
  );

  assign a_group_output_cells_o = output_logic_cell[7:0];
  assign b_group_output_cells_o = output_logic_cell[15:8];

  // input cells of ports A, B, C store pin levels on the capture strobe
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      in_cells <= '0;
    else
    begin
      for (int c = 0; c < 3; c++)
        if (in_cell_capture_i[c])
          in_cells[c] <= port_pins_i[c]; // R12
    end
  end

  assign input_logic_cell_o = in_cells; // R12

  // data source per pin: latch, cell, chip select or address
  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
      pin_data[p] = pin_output_latch[p];
    // A pins may carry A-group cells, B pins B-group cells
    pin_data[0] = (cell_route_a_i & output_logic_cell[7:0]) |
                  (~cell_route_a_i & pin_output_latch[0]); // R14
    pin_data[1] = (cell_route_b_i & output_logic_cell[15:8]) |
                  (~cell_route_b_i & pin_output_latch[1]); // R14
    // external chip selects reach C, F or both
    if (ecs_to_c_i)
      pin_data[2] = external_chip_selects_i; // R14
    if (ecs_to_f_i)
      pin_data[5] = external_chip_selects_i; // R14
    // address output mode on E, F, G pins whose control bit is one
    for (int g = 0; g < 3; g++)
      pin_data[4 + g] = (port_setup_control[4 + g] & address_out_i[g]) |
                        (~port_setup_control[4 + g] & pin_data[4 + g]); // R17
  end

  // one driver slice per port
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    pcr_pin_drive #(
      .PORT(4'(p))
    ) u_drive (
      .dir_i(pin_dir_select[p]),
      .array_oe_i(array_oe_i[p]),
      .data_i(pin_data[p]),
      .style_i(pin_driver_style[p]),
      .pin_out_o(pin_out_o[p]),
      .pin_oe_o(pin_oe_o[p]),
      .fast_slew_o(fast_slew_o[p]),
      .active_o(driver_active[p])
    );
  end

  // read selection for the addressed register
  logic [7:0] rd_value;
  always_comb
  begin
    rd_value = 8'h00;
    case (sel_reg)
      REG_PIN_LEVEL:
        rd_value = port_pins_i[sel_port[2:0]] & sel_mask; // R8
      REG_CONTROL:
        rd_value = ctrl_port ? port_setup_control[sel_port[2:0]] : 8'h00;
      REG_OUT_LATCH:
        rd_value = pin_output_latch[sel_port[2:0]]; // R9
      REG_DIR:
        rd_value = pin_dir_select[sel_port[2:0]]; // R1
      REG_DRIVER:
        rd_value = pin_driver_style[sel_port[2:0]];
      REG_CELL_ACCESS:
        if (sel_port == PORT_A)
          rd_value = output_logic_cell[7:0]; // R10
        else if (sel_port == PORT_B)
          rd_value = output_logic_cell[15:8]; // R10
      REG_LOAD_BLOCK:
        if (sel_port == PORT_A)
          rd_value = logic_cell_load_block[7:0];
        else if (sel_port == PORT_B)
          rd_value = logic_cell_load_block[15:8];
      REG_IN_CELL:
        if (sel_port <= PORT_C)
          rd_value = in_cells[sel_port[1:0]]; // R12
      REG_DRV_STATUS:
        if (has_array_oe(sel_port))
          rd_value = driver_active[sel_port[2:0]]; // R13
      default:
        rd_value = 8'h00;
    endcase
  end

  // read data register, holds the last value read
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus_rdata_o <= REG_RESET;
    else if (rd_go)
      bus_rdata_o <= rd_value; // R19
  end

  // read-only indexes (pin level, input cell, driver status) have no
  // write strobe above, so writes there leave every flop untouched: R18

endmodule // pcr_port_regs

// ---- design/pcr_pkg.sv ----
// constants and helpers for the port configuration and data registers
//
// Overview of operation
// R1: direction bit one makes the pin an output, zero an input.
// R2: after reset every pin is an input and nothing is driven.
// R3: ports A, B, C, F drive when direction or logic-array enable is one.
// R4: port D direction register keeps only its four low bits.
// R5: drive bit one selects open-drain where capable; default push-pull.
// R6: drive bit one selects fast slew where offered; default slow.
// R7: open-drain on A, B, E, G, D[3:0]; slew on C, F; D[7:4] unused.
// R8: pin level register returns live pin levels, not the latch.
// R9: output latch stores writes, reads back, drives only when enabled.
// R10: ports A, B cell access reads cell flops, writes unmasked bits.
// R11: each load-block bit one stops bus loads into its cell; resets zero.
// R12: input cells of A, B, C store inputs, feed array, read back.
// R13: driver status on A, B, C, F reads one per driven pin.
// R14: A pins carry A-group cells, B pins B-group, selects to C or F.
// R15: each configuration bit acts only on the pin of the same position.
// R16: control, direction and drive registers reset to zero.
// R17: on E, F, G control bit one gives address output mode.
// R18: writes to read-only locations change nothing.
// R19: each register is eight bits, reached by plain reads and writes.
package pcr_pkg;

  localparam int NUM_PORTS = 7;
  localparam int PORT_W = 8;

  // port numbers, also the high address nibble
  localparam logic [3:0] PORT_A = 4'h0;
  localparam logic [3:0] PORT_B = 4'h1;
  localparam logic [3:0] PORT_C = 4'h2;
  localparam logic [3:0] PORT_D = 4'h3;
  localparam logic [3:0] PORT_E = 4'h4;
  localparam logic [3:0] PORT_F = 4'h5;
  localparam logic [3:0] PORT_G = 4'h6;

  // register index within a port, the low address nibble
  localparam logic [3:0] REG_PIN_LEVEL = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h2;
  localparam logic [3:0] REG_OUT_LATCH = 4'h4;
  localparam logic [3:0] REG_DIR = 4'h6;
  localparam logic [3:0] REG_DRIVER = 4'h8;
  localparam logic [3:0] REG_CELL_ACCESS = 4'hA;
  localparam logic [3:0] REG_LOAD_BLOCK = 4'hC;
  localparam logic [3:0] REG_IN_CELL = 4'hE;
  localparam logic [3:0] REG_DRV_STATUS = 4'hF;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [7:0] PORT_D_MASK = 8'h0F;

  // implemented pin bits of a port
  function automatic logic [7:0] port_mask(input logic [3:0] p);
    return (p == PORT_D) ? PORT_D_MASK : FULL_MASK;
  endfunction

  // ports whose direction also follows the logic-array enable term
  function automatic logic has_array_oe(input logic [3:0] p);
    return (p == PORT_A) || (p == PORT_B) || (p == PORT_C) ||
           (p == PORT_F);
  endfunction

  // ports whose drive bits select slew rather than open-drain
  function automatic logic is_slew_port(input logic [3:0] p);
    return (p == PORT_C) || (p == PORT_F);
  endfunction

endpackage

// ---- design/pcr_pin_drive.sv ----
// pin driver of one port: direction, enable term and driver style
`timescale 1ns/1ps
module pcr_pin_drive
  import pcr_pkg::*;
#(
  parameter logic [3:0] PORT = 4'h0
)
(
  input wire logic [7:0] dir_i,
  input wire logic [7:0] array_oe_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] style_i,
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] fast_slew_o,
  output logic [7:0] active_o
);

  localparam logic [7:0] MASK = port_mask(PORT);
  localparam logic USE_OE = has_array_oe(PORT);
  localparam logic SLEW = is_slew_port(PORT);

  wire logic [7:0] oe_term = USE_OE ? array_oe_i : 8'h00;
  wire logic [7:0] open_drain = SLEW ? 8'h00 : (style_i & MASK); // R7

  // driver enabled from direction or array term, bit for bit
  assign active_o = (dir_i | oe_term) & MASK; // R1 R3 R15
  // open-drain pins only pull low and float for a one
  assign pin_oe_o = active_o & ~(open_drain & data_i); // R5 R9
  assign pin_out_o = data_i & ~open_drain & MASK; // R5
  assign fast_slew_o = SLEW ? style_i : 8'h00; // R6 R7

endmodule // pcr_pin_drive

// ---- design/pcr_out_cells.sv ----
// output logic cell flip-flops with bus load and load blocking
`timescale 1ns/1ps
module pcr_out_cells
  import pcr_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] bus_we_i,
  input wire logic [W-1:0] bus_data_i,
  input wire logic [W-1:0] block_i,
  input wire logic [W-1:0] array_load_i,
  input wire logic [W-1:0] array_next_i,
  output logic [W-1:0] cells_o
);

  // a bus load only reaches cells whose block bit is clear
  wire logic [W-1:0] bus_load = bus_we_i & ~block_i; // R10 R11
  wire logic [W-1:0] next_cells =
    (bus_load & bus_data_i) |
    (~bus_load & array_load_i & array_next_i) |
    (~bus_load & ~array_load_i & cells_o);

  // cell flops, bus load wins over the array update
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cells_o <= '0;
    else
      cells_o <= next_cells;
  end

endmodule // pcr_out_cells

// ---- verification/pcr_port_regs_properties.sv ----
// checker on the pins of the port register block
`timescale 1ns/1ps
module pcr_regs_chk
  import pcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic bus_cs_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic [6:0][7:0] port_pins_i,
  input wire logic [6:0][7:0] pin_oe_o,
  input wire logic [6:0][7:0] fast_slew_o,
  input wire logic [6:0][7:0] array_oe_i,
  input wire logic [15:0] cell_load_i,
  input wire logic [2:0] in_cell_capture_i,
  input wire logic [7:0] a_group_output_cells_o,
  input wire logic [2:0][7:0] input_logic_cell_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic rd;
  logic wr;
  // accepted bus requests
  assign rd = bus_cs_i & bus_rd_i;
  assign wr = bus_cs_i & bus_wr_i;
  sequence rd_at(logic [7:0] a);
    rd && bus_addr_i == a;
  endsequence
  sequence wr_at(logic [7:0] a);
    wr && bus_addr_i == a;
  endsequence
  oe_or_term_a: assert property (
    (pin_oe_o[2] & array_oe_i[2]) == array_oe_i[2] &&
    (pin_oe_o[5] & array_oe_i[5]) == array_oe_i[5])
    else $error("array enable term not driving");
  port_d_top_a: assert property (
    pin_oe_o[3][7:4] == 4'h0 && fast_slew_o[3] == 8'h00)
    else $error("port d upper pins active");
  slew_ports_a: assert property (
    (fast_slew_o[0] | fast_slew_o[1] | fast_slew_o[4] | fast_slew_o[6])
    == 8'h00) else $error("slew set on open drain port");
  dir_write_a: assert property (wr_at(8'h26) |=>
    pin_oe_o[2] == ($past(bus_wdata_i) | array_oe_i[2]))
    else $error("direction write not on pins");
  level_read_a: assert property (rd_at(8'h00) |=>
    bus_rdata_o == $past(port_pins_i[0])) else $error("pin level read");
  status_read_a: assert property (rd_at(8'h2F) |=>
    bus_rdata_o == $past(pin_oe_o[2])) else $error("status read");
  rdata_hold_a: assert property (!rd |=> $stable(bus_rdata_o))
    else $error("read data moved without read");
  cells_hold_a: assert property (
    !wr && cell_load_i[7:0] == 8'h00 |=> $stable(a_group_output_cells_o))
    else $error("cells changed without load");
  in_cell_store_a: assert property (in_cell_capture_i[2] |=>
    input_logic_cell_o[2] == $past(port_pins_i[2]))
    else $error("input cell not stored");
  reset_state_a: assert property ($rose(rst_n_i) |->
    pin_oe_o[4] == 8'h00 && bus_rdata_o == 8'h00)
    else $error("reset state wrong");
endmodule // pcr_regs_chk

bind pcr_port_regs pcr_regs_chk i_chk (
  .clk_i, .rst_n_i, .bus_cs_i, .bus_wr_i, .bus_rd_i, .bus_addr_i,
  .bus_wdata_i, .bus_rdata_o, .port_pins_i, .pin_oe_o, .fast_slew_o,
  .array_oe_i, .cell_load_i, .in_cell_capture_i,
  .a_group_output_cells_o, .input_logic_cell_o
);

// ---- verification/pcr_pin_model.sv ----
// external pins: driven bits follow the block, released bits float
`timescale 1ns/1ps
module pcr_pin_model (
  input wire logic [6:0][7:0] out_i,
  input wire logic [6:0][7:0] oe_i,
  input wire logic [6:0][7:0] ext_i,
  output logic [6:0][7:0] pins_o
);
  // a released pin shows the outside level, pull-up when idle
  assign pins_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule // pcr_pin_model

// ---- verification/pcr_port_regs_tb_top.sv ----
// testbench of the port register block
`timescale 1ns/1ps
module pcr_port_regs_tb_top
  import pcr_pkg::*;
;
  logic clk = 0, rst_n = 0, cs = 0, wr = 0, rd = 0, ec = 0, ef = 0;
  logic [7:0] addr = '0, wdata = '0, rdata, cra = '0, crb = '0, ecs = '0;
  logic [7:0] acell, bcell;
  logic [6:0][7:0] pins, pout, poe, slew, aoe = '0, ext = '1;
  logic [15:0] cload = '0, cnext = '0;
  logic [2:0] cap = '0;
  logic [2:0][7:0] aout = '0, icell;
  int num_errors = 0, n_tests = 0;
  pcr_port_regs i_dut (
    .clk_i(clk), .rst_n_i(rst_n), .bus_cs_i(cs), .bus_wr_i(wr),
    .bus_rd_i(rd), .bus_addr_i(addr), .bus_wdata_i(wdata),
    .bus_rdata_o(rdata), .port_pins_i(pins), .pin_out_o(pout),
    .pin_oe_o(poe), .fast_slew_o(slew), .array_oe_i(aoe),
    .cell_route_a_i(cra), .cell_route_b_i(crb),
    .external_chip_selects_i(ecs), .ecs_to_c_i(ec), .ecs_to_f_i(ef),
    .cell_load_i(cload), .cell_next_i(cnext), .in_cell_capture_i(cap),
    .address_out_i(aout), .a_group_output_cells_o(acell),
    .b_group_output_cells_o(bcell), .input_logic_cell_o(icell)
  );
  pcr_pin_model i_pins (.out_i(pout), .oe_i(poe), .ext_i(ext),
    .pins_o(pins));
  // 100 MHz clock
  initial forever #5 clk = ~clk;
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one bus cycle, taken at the second edge
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    cs <= 1'b1;
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    cs <= 1'b0;
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, exp);
    bus(1'b0, a, 8'h00);
    chk(rdata, exp);
  endtask
  task automatic t_reset();
    for (int p = 0; p < 7; p++)
    begin
      rchk({p[3:0], REG_DIR}, 8'h00);
      rchk({p[3:0], REG_DRIVER}, 8'h00);
      rchk({p[3:0], REG_CONTROL}, 8'h00);
      chk(poe[p], 8'h00);
    end
  endtask
  task automatic t_dir();
    bus(1'b1, 8'h06, 8'h07);
    chk(poe[0], 8'h07);
    rchk(8'h06, 8'h07);
    bus(1'b1, 8'h36, 8'hFF);
    rchk(8'h36, 8'h0F);
    chk(poe[3], 8'h0F);
    bus(1'b1, 8'h38, 8'hFF);
    rchk(8'h38, 8'h0F);
  endtask
  task automatic t_or();
    @(posedge clk);
    aoe[2] <= 8'hF0;
    aoe[4] <= 8'hFF;
    aoe[5] <= 8'h3C;
    bus(1'b1, 8'h26, 8'h0F);
    chk(poe[2], 8'hFF);
    chk(poe[5], 8'h3C);
    rchk(8'h2F, 8'hFF);
    chk(poe[4], 8'h00);
    bus(1'b1, 8'h26, 8'h00);
    chk(poe[2], 8'hF0);
    @(posedge clk);
    aoe <= '0;
    bus(1'b1, 8'h28, 8'h5A);
    chk(slew[2], 8'h5A);
  endtask
  task automatic t_od();
    bus(1'b1, 8'h04, 8'h01);
    bus(1'b1, 8'h08, 8'h01);
    chk(poe[0], 8'h06);
    rchk(8'h00, 8'hF9);
    chk(slew[0], 8'h00);
    bus(1'b1, 8'h04, 8'h00);
    chk(poe[0], 8'h07);
    rchk(8'h0F, 8'h07);
    bus(1'b1, 8'h0F, 8'h00);
    bus(1'b1, 8'h00, 8'hFF);
    rchk(8'h0F, 8'h07);
    rchk(8'h04, 8'h00);
  endtask
  task automatic t_cells();
    bus(1'b1, 8'h0C, 8'h0F);
    bus(1'b1, 8'h0A, 8'hFF);
    chk(acell, 8'hF0);
    rchk(8'h0A, 8'hF0);
    rchk(8'h0C, 8'h0F);
    @(posedge clk);
    cra <= 8'hFF;
    ecs <= 8'h3C;
    ef <= 1'b1;
    cload <= 16'hFF00;
    cnext <= 16'h3C00;
    @(posedge clk);
    cload <= 16'h0000;
    #1;
    chk(bcell, 8'h3C);
    chk(pout[0], 8'hF0);
    chk(pout[5], 8'h3C);
  endtask
  // chip selects on C, B-group cells on B, address mode on E
  task automatic t_route();
    @(posedge clk);
    ec <= 1'b1;
    crb <= 8'hFF;
    aout[0] <= 8'hA5;
    bus(1'b1, 8'h42, 8'h0F);
    chk(pout[2], 8'h3C);
    chk(pout[1], 8'h3C);
    chk(pout[4], 8'h05);
    rchk(8'h42, 8'h0F);
    bus(1'b1, 8'h02, 8'hFF);
    rchk(8'h02, 8'h00);
  endtask
  task automatic t_incell();
    ext[2] <= 8'hA5;
    cap <= 3'b100;
    @(posedge clk);
    cap <= 3'b000;
    ext[2] <= 8'h00;
    #1;
    chk(icell[2], 8'hA5);
    rchk(8'h2E, 8'hA5);
  endtask
  // verdict
  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #100000;
    num_errors++;
    test_done();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_dir();
    t_or();
    t_od();
    t_cells();
    t_route();
    @(posedge clk);
    t_incell();
    test_done();
  end
endmodule // pcr_port_regs_tb_top
